// >>> pceo_pkg.sv
/*
  pceo_pkg: constants and carrier types for the privileged channel and
  exchange pointer instruction executor.
  assumes: 16-bit instruction parcels, 24-bit address operands,
  channels numbered 2 to 25.
*/
package pceo_pkg;
  // instruction field layout (one parcel)
  localparam int PARCEL_W   = 16;
  localparam int ADDR_W     = 24;
  localparam int GH_W       = 7;
  localparam int FLD_W      = 3;
  localparam int GH_LSB     = 9;
  localparam int I_LSB      = 6;
  localparam int J_LSB      = 3;
  localparam int K_LSB      = 0;
  // opcodes, combined g/h field
  localparam logic [GH_W-1:0]  OP_ERR_EXIT = 7'h00;
  localparam logic [GH_W-1:0]  OP_MONITOR  = 7'h01;
  // i field selects the monitor operation
  localparam logic [FLD_W-1:0] SUB_SET_CUR = 3'h0;
  localparam logic [FLD_W-1:0] SUB_SET_LIM = 3'h1;
  localparam logic [FLD_W-1:0] SUB_CHAN_FL = 3'h2;
  localparam logic [FLD_W-1:0] SUB_XPTR    = 3'h3;
  localparam logic [FLD_W-1:0] FLD_ZERO    = 3'h0;
  localparam logic [FLD_W-1:0] K_CLEAR_FL  = 3'h0;
  localparam logic [FLD_W-1:0] K_DEV_RESET = 3'h1;
  // channel numbering
  localparam int CH_W    = 5;
  localparam int CH_LO   = 2;
  localparam int CH_HI   = 25;
  localparam int CH_N    = CH_HI - CH_LO + 1;
  localparam logic [ADDR_W-1:0] CH_LO_V = 24'h000002;
  localparam logic [ADDR_W-1:0] CH_HI_V = 24'h000019;
  // special operand values and field spans
  localparam logic [ADDR_W-1:0] AK_ZERO_VAL = 24'h000001;
  localparam logic [ADDR_W-1:0] ADDR_ZERO   = 24'h000000;
  localparam logic [ADDR_W-1:0] PARCEL_STEP = 24'h000001;
  localparam int XP_W   = 8;
  localparam int XP_LSB = 12;
  localparam logic [XP_W-1:0] XP_RESET = 8'h00;

  // one decoded issue request
  typedef struct packed {
    logic              valid;
    logic [PARCEL_W-1:0] parcel;
    logic [ADDR_W-1:0] pa;     // parcel address of this instruction
    logic [ADDR_W-1:0] aj;     // (Aj)
    logic [ADDR_W-1:0] ak;     // (Ak)
  } pceo_issue_t;

  // exchange request toward the exchange sequencer
  typedef struct packed {
    logic              start;
    logic [XP_W-1:0]   ptr;
    logic [ADDR_W-1:0] save_pa;
  } pceo_xchg_t;
endpackage : pceo_pkg

// >>> pceo_exec.sv
/*
  pceo_exec: executes the error exit and the monitor-mode channel and
  exchange pointer instructions, and holds per-channel address state.
  assumes: one instruction offered per issue, operands already read;
  the pipeline reports when earlier results have landed; channel
  engines pulse a word strobe for each word moved.
*/
// Summary of operation
// - monitor ops act only in monitor mode
// - don't-care fields never affect execution
// - zero opcode: error, exchange, void buffers
// - error exit outside monitor sets flag
// - drain earlier results, then exchange via pointer
// - saved address is own parcel plus one
// - low nine operand bits of error exit ignored
// - start op loads current pointer, activates channel
// - transfer increments pointer, ends at limit
// - channel ops pass on j zero, bad channel
// - start op with k zero loads one
// - set-limit op loads channel limit pointer
// - set-limit with k zero loads one
// - clear op clears irq and error flags
// - reset op: master clear out, ready clear in
// - pointer op copies Aj bits 12..19
// - pointer op with j zero clears pointer
`timescale 1ns/1ps
module pceo_exec (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  // issue stage
  input  wire pceo_pkg::pceo_issue_t      issue,
  input  wire logic                       monitor_mode,
  input  wire logic                       results_drained,
  output logic                            issue_ready,
  // exchange mechanism
  output pceo_pkg::pceo_xchg_t            xchg,
  output logic                            ibuf_void,
  output logic                            err_exit_flag_set,
  output logic [pceo_pkg::XP_W-1:0]       exchange_block_pointer,
  // channels, bit n-2 is channel n
  input  wire logic [pceo_pkg::CH_N-1:0]  ch_is_output,
  input  wire logic [pceo_pkg::CH_N-1:0]  ch_word_strobe,
  input  wire logic [pceo_pkg::CH_N-1:0]  ch_irq_set,
  input  wire logic [pceo_pkg::CH_N-1:0]  ch_err_set,
  output logic [pceo_pkg::CH_N-1:0]       ch_active,
  output logic [pceo_pkg::CH_N-1:0]       ch_done,
  output logic [pceo_pkg::CH_N-1:0]       ch_irq_flag,
  output logic [pceo_pkg::CH_N-1:0]       ch_err_flag,
  output logic [pceo_pkg::CH_N-1:0]       device_master_reset_op,
  output logic [pceo_pkg::CH_N-1:0]       ch_ready_clear,
  output logic [pceo_pkg::CH_N*pceo_pkg::ADDR_W-1:0]
                                          channel_current_word_pointer,
  output logic [pceo_pkg::CH_N*pceo_pkg::ADDR_W-1:0]
                                          channel_limit_pointer
);
  import pceo_pkg::*;

  typedef enum logic [1:0] {
    PCEO_IDLE,
    PCEO_DRAIN,
    PCEO_XCHG
  } pceo_state_t;

  //////////////////////////////////////////////////////////////////////
  // field decode; only the fields each op names are looked at
  logic [GH_W-1:0]  f_gh;
  logic [FLD_W-1:0] f_i;
  logic [FLD_W-1:0] f_j;
  logic [FLD_W-1:0] f_k;
  logic             is_err;
  logic             is_mon;
  logic             ch_ok;
  logic [CH_W-1:0]  ch_idx;
  logic [ADDR_W-1:0] ak_val;
  logic [ADDR_W-1:0] ch_off;

  assign f_gh   = issue.parcel[GH_LSB +: GH_W];
  assign f_i    = issue.parcel[I_LSB +: FLD_W];
  assign f_j    = issue.parcel[J_LSB +: FLD_W];
  assign f_k    = issue.parcel[K_LSB +: FLD_W];
  // ijk of the error exit are never decoded
  assign is_err = issue.valid && (f_gh == OP_ERR_EXIT);
  // monitor ops vanish outside monitor mode
  assign is_mon = issue.valid && (f_gh == OP_MONITOR) && monitor_mode;
  // j zero or channel out of 2..25 makes the op a pass
  assign ch_ok  = (f_j != FLD_ZERO) && (issue.aj >= CH_LO_V)
                  && (issue.aj <= CH_HI_V);
  assign ch_off = issue.aj - CH_LO_V;
  assign ch_idx = ch_off[CH_W-1:0];
  // k zero supplies the constant one
  assign ak_val = (f_k == FLD_ZERO) ? AK_ZERO_VAL : issue.ak;

  //////////////////////////////////////////////////////////////////////
  // error exit sequencer state
  pceo_state_t       state;
  pceo_state_t       next_state;
  pceo_xchg_t        next_xchg;
  logic              next_ibuf_void;
  logic              next_err_flag;
  logic [ADDR_W-1:0] save_pa;
  logic [ADDR_W-1:0] next_save_pa;
  logic [XP_W-1:0]   next_xptr;

  // later instructions stall while an error exit is in flight
  assign issue_ready = (state == PCEO_IDLE);

  // error exit waits for earlier results before exchanging
  always_comb begin
    next_state     = state;
    next_save_pa   = save_pa;
    next_xchg      = '0;
    next_ibuf_void = 1'b0;
    next_err_flag  = 1'b0;
    next_xptr      = exchange_block_pointer;
    case (state)
      PCEO_IDLE: begin
        if (is_err) begin
          next_save_pa  = issue.pa + PARCEL_STEP;
          next_err_flag = !monitor_mode;
          next_state    = PCEO_DRAIN;
        end else if (is_mon && (f_i == SUB_XPTR)) begin
          if (f_j == FLD_ZERO) begin
            next_xptr = XP_RESET;
          end else begin
            next_xptr = issue.aj[XP_LSB +: XP_W];
          end
        end
      end
      PCEO_DRAIN: begin
        if (results_drained) begin
          next_state = PCEO_XCHG;
        end
      end
      PCEO_XCHG: begin
        // pointer is taken as it stands at exchange time
        next_xchg.start   = 1'b1;
        next_xchg.ptr     = exchange_block_pointer;
        next_xchg.save_pa = save_pa;
        next_ibuf_void    = 1'b1;
        next_state        = PCEO_IDLE;
      end
      default: begin
        next_state = PCEO_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state                  <= PCEO_IDLE;
      save_pa                <= ADDR_ZERO;
      xchg                   <= '0;
      ibuf_void              <= 1'b0;
      err_exit_flag_set      <= 1'b0;
      exchange_block_pointer <= XP_RESET;
    end else begin
      state                  <= next_state;
      save_pa                <= next_save_pa;
      xchg                   <= next_xchg;
      ibuf_void              <= next_ibuf_void;
      err_exit_flag_set      <= next_err_flag;
      exchange_block_pointer <= next_xptr;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // per-channel state; no order check on limit vs start
  logic [CH_N-1:0] sel;
  logic            op_cur;
  logic            op_lim;
  logic            op_clr;
  logic            op_rst;

  assign op_cur = is_mon && ch_ok && (f_i == SUB_SET_CUR);
  assign op_lim = is_mon && ch_ok && (f_i == SUB_SET_LIM);
  assign op_clr = is_mon && ch_ok && (f_i == SUB_CHAN_FL)
                  && (f_k == K_CLEAR_FL);
  assign op_rst = is_mon && ch_ok && (f_i == SUB_CHAN_FL)
                  && (f_k == K_DEV_RESET);

  genvar g;
  generate
    for (g = 0; g < CH_N; g++) begin : g_ch
      logic [ADDR_W-1:0] cur;
      logic [ADDR_W-1:0] lim;
      logic              act;
      logic              irq;
      logic              err;
      logic              done;
      logic              mrst;
      logic              rdyc;
      logic [ADDR_W-1:0] next_cur;
      logic [ADDR_W-1:0] next_lim;
      logic              next_act;
      logic              next_irq;
      logic              next_err;
      logic              next_done;
      logic              next_mrst;
      logic              next_rdyc;

      assign sel[g] = (ch_idx == CH_W'(g));

      // channel load, count and flag updates
      always_comb begin
        next_cur  = cur;
        next_lim  = lim;
        next_act  = act;
        next_done = 1'b0;
        next_mrst = 1'b0;
        next_rdyc = 1'b0;
        next_irq  = irq;
        next_err  = err;
        if (op_lim && sel[g]) begin
          next_lim = ak_val;
        end
        if (op_cur && sel[g]) begin
          next_cur = ak_val;
          next_act = 1'b1;
        end else if (act) begin
          // words run from start through limit minus one
          if (cur == lim) begin
            next_act  = 1'b0;
            next_done = 1'b1;
          end else if (ch_word_strobe[g]) begin
            next_cur = cur + PARCEL_STEP;
          end
        end
        if (op_clr && sel[g]) begin
          next_irq = 1'b0;
          next_err = 1'b0;
        end
        if (op_rst && sel[g]) begin
          next_mrst = ch_is_output[g];
          next_rdyc = !ch_is_output[g];
        end
        // a set arriving with the clear still wins
        if (ch_irq_set[g]) begin
          next_irq = 1'b1;
        end
        if (ch_err_set[g]) begin
          next_err = 1'b1;
        end
      end

      // channel registers
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          cur  <= ADDR_ZERO;
          lim  <= ADDR_ZERO;
          act  <= 1'b0;
          irq  <= 1'b0;
          err  <= 1'b0;
          done <= 1'b0;
          mrst <= 1'b0;
          rdyc <= 1'b0;
        end else begin
          cur  <= next_cur;
          lim  <= next_lim;
          act  <= next_act;
          irq  <= next_irq;
          err  <= next_err;
          done <= next_done;
          mrst <= next_mrst;
          rdyc <= next_rdyc;
        end
      end

      assign ch_active[g]              = act;
      assign ch_done[g]                = done;
      assign ch_irq_flag[g]            = irq;
      assign ch_err_flag[g]            = err;
      assign device_master_reset_op[g] = mrst;
      assign ch_ready_clear[g]         = rdyc;
      assign channel_current_word_pointer[g*ADDR_W +: ADDR_W] = cur;
      assign channel_limit_pointer[g*ADDR_W +: ADDR_W]        = lim;
    end
  endgenerate
endmodule : pceo_exec

// >>> pceo_chan_model.sv
/*
  pceo_chan_model: stand-in for the I/O channel hardware.
  assumes: one word strobe per cycle for each active channel.
*/
`timescale 1ns/1ps
module pceo_chan_model (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      nrst,
  // bench control and executor state
  input  wire logic                      stall,
  input  wire logic [pceo_pkg::CH_N-1:0] ch_active,
  // toward the executor
  output logic [pceo_pkg::CH_N-1:0]      ch_word_strobe,
  output logic [pceo_pkg::CH_N-1:0]      ch_is_output
);
  import pceo_pkg::*;
  // even bits output, odd bits input, so both reset kinds get exercised
  assign ch_is_output = 24'h555555;
  // a stalled channel moves nothing; strobes lag active by one cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) ch_word_strobe <= '0;
    else ch_word_strobe <= stall ? '0 : ch_active;
  end
endmodule : pceo_chan_model

// >>> pceo_exec_chk.sv
/*
  pceo_exec_chk: port-level assertions for pceo_exec.
  assumes: bound onto every pceo_exec instance.
*/
`timescale 1ns/1ps
module pceo_exec_chk (
  // clock and reset
  input wire logic                     ref_clk,
  input wire logic                     nrst,
  // issue side
  input wire pceo_pkg::pceo_issue_t    issue,
  input wire logic                     monitor_mode,
  input wire logic                     results_drained,
  input wire logic                     issue_ready,
  // exchange side
  input wire pceo_pkg::pceo_xchg_t     xchg,
  input wire logic                     ibuf_void,
  input wire logic                     err_exit_flag_set,
  input wire logic [pceo_pkg::XP_W-1:0] exchange_block_pointer,
  // channel side
  input wire logic [pceo_pkg::CH_N-1:0] ch_is_output,
  input wire logic [pceo_pkg::CH_N-1:0] ch_active,
  input wire logic [pceo_pkg::CH_N-1:0] ch_done,
  input wire logic [pceo_pkg::CH_N-1:0] device_master_reset_op,
  input wire logic [pceo_pkg::CH_N-1:0] ch_ready_clear,
  input wire logic [pceo_pkg::CH_N*pceo_pkg::ADDR_W-1:0]
    channel_current_word_pointer,
  input wire logic [pceo_pkg::CH_N*pceo_pkg::ADDR_W-1:0]
    channel_limit_pointer
);
  import pceo_pkg::*;
  logic              err_take;
  logic              xp_take;
  logic [ADDR_W-1:0] pa_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////
  // requests as taken at the port
  assign err_take = issue.valid && issue_ready
                    && issue.parcel[15:9] == OP_ERR_EXIT;
  assign xp_take = issue.valid && issue_ready
                   && issue.parcel[15:6] == {OP_MONITOR, SUB_XPTR};
  // parcel address of the error exit in flight
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) pa_q <= '0;
    else if (err_take) pa_q <= issue.pa;
  end
  ////////////////////////////////////////////////////////////////////////
  err_flag_a: assert property (
    err_take |=> err_exit_flag_set == !$past(monitor_mode))
    else $error("error exit flag wrong");
  drain_busy_a: assert property (err_take |=> !issue_ready)
    else $error("issue accepted while draining");
  drain_wait_a: assert property (
    xchg.start |-> $past(results_drained, 2))
    else $error("exchange before results landed");
  xchg_ptr_a: assert property (
    xchg.start |-> xchg.ptr == exchange_block_pointer)
    else $error("exchange pointer wrong");
  save_pa_a: assert property (
    xchg.start |-> xchg.save_pa == pa_q + PARCEL_STEP)
    else $error("saved address wrong");
  void_pair_a: assert property (ibuf_void == xchg.start)
    else $error("buffer void not with exchange");
  xptr_load_a: assert property (
    xp_take && monitor_mode |=> exchange_block_pointer ==
    ($past(issue.parcel[5:3]) == FLD_ZERO ? XP_RESET : $past(issue.aj[19:12])))
    else $error("pointer load wrong");
  xptr_priv_a: assert property (
    xp_take && !monitor_mode |=> $stable(exchange_block_pointer))
    else $error("pointer load outside monitor");
  done_end_a: assert property (
    ch_done[0] |-> !ch_active[0] && $past(channel_current_word_pointer[23:0]
    == channel_limit_pointer[23:0]))
    else $error("transfer end wrong");
  reset_kind_a: assert property (
    ((device_master_reset_op & ~ch_is_output)
    | (ch_ready_clear & ch_is_output)) == '0)
    else $error("reset kind wrong");
  // main scenarios reached
  cover property (xchg.start);
  cover property (ch_done[0]);
  cover property (|ch_ready_clear);
endmodule : pceo_exec_chk

bind pceo_exec pceo_exec_chk pceo_exec_chk_i (.ref_clk, .nrst, .issue,
  .monitor_mode, .results_drained, .issue_ready, .xchg, .ibuf_void,
  .err_exit_flag_set, .exchange_block_pointer, .ch_is_output, .ch_active,
  .ch_done, .device_master_reset_op, .ch_ready_clear,
  .channel_current_word_pointer, .channel_limit_pointer);

// >>> privileged_channel_exchange_ops_tb.sv
/*
  privileged_channel_exchange_ops_tb: directed bench for pceo_exec.
  assumes: channel model supplies word strobes; inputs move at negedge.
*/
`timescale 1ns/1ps
module privileged_channel_exchange_ops_tb;
  import pceo_pkg::*;
  logic                   ref_clk, nrst, monitor_mode, results_drained;
  logic                   issue_ready, ibuf_void, err_exit_flag_set, stall;
  pceo_issue_t            issue;
  pceo_xchg_t             xchg;
  logic [XP_W-1:0]        exchange_block_pointer;
  logic [CH_N-1:0]        ch_is_output, ch_word_strobe, ch_irq_set;
  logic [CH_N-1:0]        ch_err_set, ch_active, ch_done, ch_irq_flag;
  logic [CH_N-1:0]        ch_err_flag, device_master_reset_op;
  logic [CH_N-1:0]        ch_ready_clear;
  logic [CH_N*ADDR_W-1:0] channel_current_word_pointer;
  logic [CH_N*ADDR_W-1:0] channel_limit_pointer;
  int                     fail_count, compares;
  pceo_exec pceo_exec_i (.*);
  pceo_chan_model pceo_chan_model_i (.ref_clk, .nrst, .stall, .ch_active,
    .ch_word_strobe, .ch_is_output);
  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run(input bit hang);
    if (hang) fail_count++;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [ADDR_W-1:0] got, exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one instruction for one cycle; results are settled on return
  task automatic iss(input logic [GH_W-1:0] gh, input logic [FLD_W-1:0] i,
                     j, k, input logic [ADDR_W-1:0] pa, aj, ak);
    @(negedge ref_clk);
    issue <= '{1'b1, {gh, i, j, k}, pa, aj, ak};
    @(negedge ref_clk);
    issue.valid <= 1'b0;
  endtask : iss
  function automatic logic [ADDR_W-1:0] ptr(input bit l, input int n);
    return l ? channel_limit_pointer[(n-CH_LO)*ADDR_W +: ADDR_W]
             : channel_current_word_pointer[(n-CH_LO)*ADDR_W +: ADDR_W];
  endfunction : ptr
  ////////////////////////////////////////////////////////////////////////
  task automatic t_chan();
    int n;
    iss(OP_MONITOR, SUB_SET_LIM, 3'h3, 3'h2, 0, 24'h2, 24'h7);
    chk(ptr(1, 2), 24'h7);
    stall <= 1'b1;
    iss(OP_MONITOR, SUB_SET_CUR, 3'h3, 3'h2, 0, 24'h2, 24'h5);
    chk({ptr(0, 2)[22:0], ch_active[0]}, 24'hB);
    stall <= 1'b0;
    for (n = 0; n < 20 && ch_done[0] !== 1'b1; n++) @(negedge ref_clk);
    if (n == 20) complete_run(1'b1);
    chk({ptr(0, 2)[22:0], ch_active[0]}, 24'hE);
    iss(OP_MONITOR, SUB_SET_LIM, 3'h1, FLD_ZERO, 0, 24'h3, 24'h9);
    chk(ptr(1, 3), 24'h1);
    iss(OP_MONITOR, SUB_SET_CUR, 3'h1, FLD_ZERO, 0, 24'h3, 24'h9);
    chk(ptr(0, 3), 24'h1);
    $display("t_chan done");
  endtask : t_chan
  // outside monitor, j zero, channel 4 and channels 1 and 26
  task automatic t_pass();
    logic [CH_N*ADDR_W-1:0] snap;
    logic [ADDR_W-1:0]      ajs [4];
    ajs = '{24'h4, 24'h4, 24'h1, 24'h1A};
    snap = channel_limit_pointer ^ channel_current_word_pointer;
    for (int c = 0; c < 8; c++) begin
      monitor_mode <= c % 4 != 0;
      iss(OP_MONITOR, FLD_W'(c / 4), c % 4 == 1 ? FLD_ZERO : 3'h4, 3'h2,
          24'h0, ajs[c % 4], 24'h33);
      chk(24'(snap !== (channel_limit_pointer
          ^ channel_current_word_pointer)), 24'h0);
    end
    monitor_mode <= 1'b1;
    iss(OP_MONITOR, SUB_SET_LIM, 3'h3, 3'h2, 0, 24'h19, 24'h3);
    chk(ptr(1, 25), 24'h3);
    $display("t_pass done");
  endtask : t_pass
  task automatic t_flags();
    ch_irq_set <= 24'h8;
    ch_err_set <= 24'h8;
    @(negedge ref_clk);
    ch_irq_set <= '0;
    ch_err_set <= '0;
    for (int c = 0; c < 3; c++) begin
      monitor_mode <= c != 1;
      iss(OP_MONITOR, SUB_CHAN_FL, 3'h1, K_CLEAR_FL, 0,
          c == 0 ? 24'h1A : 24'h5, 0);
      chk(24'({ch_irq_flag[3], ch_err_flag[3]}),
          c == 2 ? 24'h0 : 24'h3);
    end
    // channel 2 is an output, channel 3 an input
    iss(OP_MONITOR, SUB_CHAN_FL, 3'h4, K_DEV_RESET, 0, 24'h2, 0);
    chk(24'({device_master_reset_op[1:0], ch_ready_clear[1:0]}),
        24'h4);
    iss(OP_MONITOR, SUB_CHAN_FL, 3'h4, K_DEV_RESET, 0, 24'h3, 0);
    chk(24'({device_master_reset_op[1:0], ch_ready_clear[1:0]}),
        24'h2);
    $display("t_flags done");
  endtask : t_flags
  task automatic t_xptr();
    iss(OP_MONITOR, SUB_XPTR, 3'h5, FLD_ZERO, 0, 24'hFAB123, 0);
    chk(24'(exchange_block_pointer), 24'hAB);
    monitor_mode <= 1'b0;
    iss(OP_MONITOR, SUB_XPTR, 3'h5, FLD_ZERO, 0, 24'h0CD000, 0);
    chk(24'(exchange_block_pointer), 24'hAB);
    monitor_mode <= 1'b1;
    iss(OP_MONITOR, SUB_XPTR, FLD_ZERO, FLD_ZERO, 0, 24'h0CD000, 0);
    chk(24'(exchange_block_pointer), 24'h0);
    iss(OP_MONITOR, SUB_XPTR, 3'h2, FLD_ZERO, 0, 24'h05A000, 0);
    chk(24'(exchange_block_pointer), 24'h5A);
    $display("t_xptr done");
  endtask : t_xptr
  // error exit with every low field bit set, exchange held off a while
  task automatic t_err(input logic mon);
    int n;
    monitor_mode <= mon;
    results_drained <= 1'b0;
    iss(OP_ERR_EXIT, 3'h7, 3'h7, 3'h7, 24'h000FFF, 24'h3, 24'h4);
    chk(24'({err_exit_flag_set, issue_ready}), 24'({!mon, 1'b0}));
    repeat (3) @(negedge ref_clk);
    chk(24'(xchg.start), 24'h0);
    results_drained <= 1'b1;
    for (n = 0; n < 10 && xchg.start !== 1'b1; n++) @(negedge ref_clk);
    if (n == 10) complete_run(1'b1);
    chk(xchg.save_pa, 24'h001000);
    chk(24'({xchg.ptr, ibuf_void}), 24'h0B5);
    $display("t_err done");
  endtask : t_err
  ////////////////////////////////////////////////////////////////////////
  // reset for 8 cycles, then the scenarios in turn
  initial begin
    nrst = 1'b0;
    monitor_mode = 1'b1;
    results_drained = 1'b1;
    stall = 1'b0;
    ch_irq_set = '0;
    ch_err_set = '0;
    issue = '0;
    fail_count = 0;
    compares = 0;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk) nrst = 1'b1;
    t_chan();
    t_pass();
    t_flags();
    t_xptr();
    t_err(1'b0);
    t_err(1'b1);
    complete_run(1'b0);
  end
endmodule : privileged_channel_exchange_ops_tb
